//--- hdl/ckl_pkg.sv
// Operation
// - Hardware clears the initialize bit when the RAM initialization sweep has finished.
// - Each key spans one, two, four, eight or sixteen entry words and its class follows from that count.
// - Key widths are 35; 69, 68, 69; 129 to 137; 255 to 272; 536 and 527 bits per class.
// - Two-, four- and eight-word keys start with a 2-bit type selector.
// - Sixteen-word keys start with a 1-bit type selector.
// - A 1-bit first-lookup flag is set for the first lookup and clear for later ones.
// - Keys with a 12-bit generic index carry a 1-bit flag set when it holds the service index (here only the indexed three-tag key; the label keys omit it).
// - Full normal keys carry a 53-bit ingress port bitmap with a 2-bit mode selector.
// - Outer tag gives a 3-bit protocol code, 3-bit priority, 1-bit drop flag and 12-bit VLAN id where present (indexed three-tag key: code and id only).
// - Second tag gives a 3-bit protocol code, 3-bit priority and 1-bit drop flag where present (the indexed three-tag key omits the priority and drop flag).
package ckl_pkg;
  // config RAM sweep
  localparam int CFG_RAM_ADDR_W = 8;
  localparam logic [CFG_RAM_ADDR_W-1:0] CFG_RAM_LAST = 8'hFF;
  localparam int CFG_RAM_DATA_W = 32;
  // key sizes and label stack field widths
  localparam int KEY_W = 536;
  localparam int SGL_LBL_W = 35;
  localparam int THREE_VLAN_W = 69;
  localparam int DBL_LBL_W = 68;
  localparam int THREE_VLAN_IDX_W = 69;
  localparam int LBL_W = 20;
  localparam int TC_W = 3;
  // field widths
  localparam int SEL2_W = 2;
  localparam int SEL16_W = 1;
  localparam int PORT_W = 6;
  localparam int GIDX_W = 12;
  localparam int MASK_W = 53;
  localparam int MASK_SEL_W = 2;
  localparam int TPID_W = 3;
  localparam int PCP_W = 3;
  localparam int VID_W = 12;
  // selector codes of the two-word class
  localparam logic [1:0] SEL_THREE_VLAN = 2'h0;
  localparam logic [1:0] SEL_DBL_LBL = 2'h1;
  localparam logic [1:0] SEL_THREE_VLAN_IDX = 2'h2;
  typedef enum logic [2:0] {CKL_X1, CKL_X2, CKL_X4, CKL_X8, CKL_X16} ckl_class_t;
  typedef enum logic [1:0] {CKL_SGL_LBL, CKL_THREE_VLAN, CKL_DBL_LBL, CKL_THREE_VLAN_IDX} ckl_key_t;
endpackage

//--- hdl/ckl_cfg_ram.sv
`timescale 1ns/10ps
// small single-port config memory, registered read data
module ckl_cfg_ram (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [ckl_pkg::CFG_RAM_ADDR_W-1:0] addr,
  input wire logic [ckl_pkg::CFG_RAM_DATA_W-1:0] wdata,
  output logic [ckl_pkg::CFG_RAM_DATA_W-1:0] rdata
);
  logic [ckl_pkg::CFG_RAM_DATA_W-1:0] mem [0:(1<<ckl_pkg::CFG_RAM_ADDR_W)-1];

  // no reset on the array; the init sweep clears it instead
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- hdl/classifier_key_layout_init.sv
`timescale 1ns/10ps
// config RAM init sequencer plus small-key builder for the classification match lookup
module ckl_classifier_key_layout_init (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfgRamEnable,
  input wire logic cfgRamInitSet,
  output logic cfgRamInit,
  input wire logic cfgWe,
  input wire logic [ckl_pkg::CFG_RAM_ADDR_W-1:0] cfgAddr,
  input wire logic [ckl_pkg::CFG_RAM_DATA_W-1:0] cfgWdata,
  output logic [ckl_pkg::CFG_RAM_DATA_W-1:0] cfgRdata,
  input wire logic keyReq,
  input wire ckl_pkg::ckl_key_t keySel,
  input wire logic firstLookup,
  input wire logic indexIsService,
  input wire logic [ckl_pkg::GIDX_W-1:0] genericIndex,
  input wire logic [ckl_pkg::PORT_W-1:0] ingressPort,
  input wire logic [ckl_pkg::TPID_W-1:0] outerTagProtocolCode,
  input wire logic [ckl_pkg::PCP_W-1:0] outerPcp,
  input wire logic outerDei,
  input wire logic [ckl_pkg::VID_W-1:0] outerVid,
  input wire logic [ckl_pkg::TPID_W-1:0] secondTagProtocolCode,
  input wire logic [ckl_pkg::PCP_W-1:0] secondPcp,
  input wire logic secondDei,
  input wire logic [ckl_pkg::VID_W-1:0] secondVid,
  input wire logic [ckl_pkg::TPID_W-1:0] thirdTagProtocolCode,
  input wire logic [ckl_pkg::PCP_W-1:0] thirdPcp,
  input wire logic thirdDei,
  input wire logic [ckl_pkg::VID_W-1:0] thirdVid,
  input wire logic [2:0] etypeClass,
  input wire logic [ckl_pkg::LBL_W-1:0] lbl0,
  input wire logic [ckl_pkg::TC_W-1:0] tc0,
  input wire logic sbit0,
  input wire logic ttl0Expiry,
  input wire logic [ckl_pkg::LBL_W-1:0] lbl1,
  input wire logic [ckl_pkg::TC_W-1:0] tc1,
  input wire logic sbit1,
  input wire logic ttl1Expiry,
  input wire logic [2:0] rsvLblPos,
  output logic keyValid,
  output logic [ckl_pkg::KEY_W-1:0] keyData,
  output logic [9:0] keyWidth,
  output ckl_pkg::ckl_class_t keyClass,
  output logic [4:0] keyWords
);
  typedef enum logic [1:0] {CKL_IDLE, CKL_SWEEP, CKL_DONE} ckl_state_t;
  ckl_state_t state;
  ckl_state_t next_state;
  logic [ckl_pkg::CFG_RAM_ADDR_W-1:0] sweepAddr;
  logic initing;

  // words per class, one place for the mapping
  // wider classes get their word counts too, although this block builds only one- and two-word keys
  function automatic logic [4:0] ckl_words(input ckl_pkg::ckl_class_t c);
    unique case (c)
      ckl_pkg::CKL_X1: ckl_words = 5'h01;
      ckl_pkg::CKL_X2: ckl_words = 5'h02;
      ckl_pkg::CKL_X4: ckl_words = 5'h04;
      ckl_pkg::CKL_X8: ckl_words = 5'h08;
      default: ckl_words = 5'h10;
    endcase
  endfunction

  // init sequencer: start needs both enable and init written as 1
  // a start seen while the sweep runs is ignored; the sweep always covers the full depth
  // cfgRamInit comes straight from the state so software sees it drop as soon as the sweep ends
  wire startInit = cfgRamEnable & cfgRamInitSet;
  wire sweepLast = (sweepAddr == ckl_pkg::CFG_RAM_LAST);
  assign initing = (state == CKL_SWEEP);
  assign cfgRamInit = initing;

  always_comb begin
    next_state = state;
    unique case (state)
      CKL_IDLE: if (startInit) next_state = CKL_SWEEP;
      CKL_SWEEP: if (sweepLast) next_state = CKL_DONE;
      CKL_DONE: if (startInit) next_state = CKL_SWEEP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= CKL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // sweep address counts through every word, clearing it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sweepAddr <= '0;
    end else if (initing) begin
      sweepAddr <= sweepAddr + 1'b1;
    end else begin
      sweepAddr <= '0;
    end
  end

  // software writes are held off while the sweep owns the RAM
  // a write that arrives mid-sweep is lost, not queued; software must poll the init flag first
  wire ramWe = initing | (cfgWe & cfgRamEnable & (state == CKL_DONE));
  wire [ckl_pkg::CFG_RAM_ADDR_W-1:0] ramAddr = initing ? sweepAddr : cfgAddr;
  wire [ckl_pkg::CFG_RAM_DATA_W-1:0] ramWdata = initing ? '0 : cfgWdata;

  ckl_cfg_ram ckl_cfg_ram_inst (
    .clk_sys(clk_sys),
    .we(ramWe),
    .addr(ramAddr),
    .wdata(ramWdata),
    .rdata(cfgRdata)
  );

  // key assembly: first field lands at bit 0, later fields follow, absent ones omitted
  // each concatenation lists the top field first, so the last item sits at bit 0
  wire [ckl_pkg::SGL_LBL_W-1:0] keySgl = {
    ttl0Expiry,
    sbit0,
    lbl0,
    genericIndex,
    firstLookup
  };

  // three-tag key: selector, first flag, port, then outer, second and third tag, frame type class
  wire [ckl_pkg::THREE_VLAN_W-1:0] keyTri = {
    etypeClass,
    thirdVid,
    thirdDei,
    thirdPcp,
    thirdTagProtocolCode,
    secondVid,
    secondDei,
    secondPcp,
    secondTagProtocolCode,
    outerVid,
    outerDei,
    outerPcp,
    outerTagProtocolCode,
    ingressPort,
    firstLookup,
    ckl_pkg::SEL_THREE_VLAN
  };

  // double-label key: selector, first flag, index, then both label stack entries and the reserved position
  wire [ckl_pkg::DBL_LBL_W-1:0] keyDbl = {
    rsvLblPos,
    ttl1Expiry,
    sbit1,
    tc1,
    lbl1,
    ttl0Expiry,
    sbit0,
    tc0,
    lbl0,
    genericIndex,
    firstLookup,
    ckl_pkg::SEL_DBL_LBL
  };

  // indexed three-tag key: only identifiers and protocol codes of the tags; the top bits belong to
  // fields this block is not given, so they are filled on purpose and read as zero
  localparam int IDX_FILL_W = ckl_pkg::THREE_VLAN_IDX_W - ckl_pkg::SEL2_W - 2 - ckl_pkg::GIDX_W
    - 3 * (ckl_pkg::TPID_W + ckl_pkg::VID_W);
  wire [ckl_pkg::THREE_VLAN_IDX_W-1:0] keyTriIdx = {
    {IDX_FILL_W{1'b0}},
    thirdVid,
    thirdTagProtocolCode,
    secondVid,
    secondTagProtocolCode,
    outerVid,
    outerTagProtocolCode,
    genericIndex,
    indexIsService,
    firstLookup,
    ckl_pkg::SEL_THREE_VLAN_IDX
  };

  // selection, width and class of the chosen key
  logic [ckl_pkg::KEY_W-1:0] next_keyData;
  logic [9:0] next_keyWidth;
  ckl_pkg::ckl_class_t next_keyClass;
  always_comb begin
    next_keyData = '0;
    next_keyWidth = 10'(ckl_pkg::SGL_LBL_W);
    next_keyClass = ckl_pkg::CKL_X1;
    unique case (keySel)
      ckl_pkg::CKL_SGL_LBL: begin
        next_keyData = {{(ckl_pkg::KEY_W-ckl_pkg::SGL_LBL_W){1'b0}}, keySgl};
      end
      ckl_pkg::CKL_THREE_VLAN: begin
        next_keyData = {{(ckl_pkg::KEY_W-ckl_pkg::THREE_VLAN_W){1'b0}}, keyTri};
        next_keyWidth = 10'(ckl_pkg::THREE_VLAN_W);
        next_keyClass = ckl_pkg::CKL_X2;
      end
      ckl_pkg::CKL_DBL_LBL: begin
        next_keyData = {{(ckl_pkg::KEY_W-ckl_pkg::DBL_LBL_W){1'b0}}, keyDbl};
        next_keyWidth = 10'(ckl_pkg::DBL_LBL_W);
        next_keyClass = ckl_pkg::CKL_X2;
      end
      ckl_pkg::CKL_THREE_VLAN_IDX: begin
        next_keyData = {{(ckl_pkg::KEY_W-ckl_pkg::THREE_VLAN_IDX_W){1'b0}}, keyTriIdx};
        next_keyWidth = 10'(ckl_pkg::THREE_VLAN_IDX_W);
        next_keyClass = ckl_pkg::CKL_X2;
      end
    endcase
  end

  // registered key output, one cycle after request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      keyValid <= 1'b0;
      keyData <= '0;
      keyWidth <= '0;
      keyClass <= ckl_pkg::CKL_X1;
      keyWords <= '0;
    end else begin
      keyValid <= keyReq;
      if (keyReq) begin
        keyData <= next_keyData;
        keyWidth <= next_keyWidth;
        keyClass <= next_keyClass;
        keyWords <= ckl_words(next_keyClass);
      end
    end
  end
endmodule

//--- dv/ckl_key_checker.sv
`timescale 1ns/10ps
// watches the init sweep and the key builder from the top ports only
module ckl_key_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfgRamEnable,
  input wire logic cfgRamInitSet,
  input wire logic cfgRamInit,
  input wire logic keyReq,
  input wire ckl_pkg::ckl_key_t keySel,
  input wire logic firstLookup,
  input wire logic keyValid,
  input wire logic [ckl_pkg::KEY_W-1:0] keyData,
  input wire logic [9:0] keyWidth,
  input wire logic [4:0] keyWords
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // sweep starts next cycle and lasts exactly 256 cycles
  a_init_start: assert property (cfgRamEnable && cfgRamInitSet && !cfgRamInit |=> cfgRamInit)
    else $error("init sweep did not start");
  a_init_clear: assert property ($rose(cfgRamInit) |-> ##255 cfgRamInit ##1 !cfgRamInit)
    else $error("init flag not cleared after sweep");
  // one answer per request, one cycle later
  a_key_answer: assert property (keyReq |=> keyValid)
    else $error("no key after request");
  a_valid_cause: assert property (keyValid |-> $past(keyReq))
    else $error("key without request");
  a_key_words: assert property (keyValid |->
    keyWords == ($past(keySel) == ckl_pkg::CKL_SGL_LBL ? 5'h01 : 5'h02))
    else $error("wrong word count");
  a_key_width: assert property (keyValid |-> keyWidth == ($past(keySel) == ckl_pkg::CKL_SGL_LBL ? 10'h023 :
    $past(keySel) == ckl_pkg::CKL_DBL_LBL ? 10'h044 : 10'h045)) else $error("wrong key width");
  // the first flag sits just above the selector, or at bit 0 when there is none
  a_first_flag: assert property (keyValid |->
    keyData[$past(keySel) == ckl_pkg::CKL_SGL_LBL ? 0 : 2] == $past(firstLookup))
    else $error("first flag misplaced");
  a_sel_field: assert property (keyValid && $past(keySel) != ckl_pkg::CKL_SGL_LBL |->
    keyData[1:0] == 2'($past(keySel)) - 2'h1)
    else $error("wrong type selector");
  a_no_pad: assert property (keyValid |-> (keyData >> keyWidth) == '0)
    else $error("bits above key width");
  c_init_done: cover property ($fell(cfgRamInit));
  c_two_word: cover property (keyValid && keyWords == 5'h02);
  c_back_to_back: cover property (keyReq ##1 keyReq);
endmodule

//--- dv/ckl_classifier_key_layout_init_test.sv
`timescale 1ns/10ps
module ckl_classifier_key_layout_init_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, cfgRamEnable = 1'b0, cfgRamInitSet = 1'b0, cfgWe = 1'b0, keyReq = 1'b0;
  logic firstLookup = 1'b0, indexIsService = 1'b0, outerDei = 1'b0, secondDei = 1'b0, thirdDei = 1'b0;
  logic sbit0 = 1'b0, ttl0Expiry = 1'b0, sbit1 = 1'b0, ttl1Expiry = 1'b0, cfgRamInit, keyValid;
  logic [7:0] cfgAddr = 8'h00;
  logic [31:0] cfgWdata = 32'h0, cfgRdata;
  logic [31:0] mem[8];
  ckl_pkg::ckl_key_t keySel = ckl_pkg::CKL_SGL_LBL;
  logic [11:0] genericIndex = 12'h0, outerVid = 12'h0, secondVid = 12'h0, thirdVid = 12'h0;
  logic [5:0] ingressPort = 6'h00;
  logic [2:0] outerTagProtocolCode = 3'h0, outerPcp = 3'h0, secondTagProtocolCode = 3'h0, secondPcp = 3'h0;
  logic [2:0] thirdTagProtocolCode = 3'h0, thirdPcp = 3'h0, etypeClass = 3'h0, tc0 = 3'h0, tc1 = 3'h0, rsvLblPos = 3'h0;
  logic [19:0] lbl0 = 20'h0, lbl1 = 20'h0;
  logic [535:0] keyData, ek;
  logic [9:0] keyWidth;
  ckl_pkg::ckl_class_t keyClass;
  logic [4:0] keyWords;
  logic [63:0] seed = 64'h18B2;
  logic [553:0] q[$];
  int n_errors = 0, n_checks = 0, i;
  always #4 clk_sys = ~clk_sys;
  ckl_classifier_key_layout_init ckl_classifier_key_layout_init_inst (.clk_sys, .rst_n, .cfgRamEnable,
    .cfgRamInitSet, .cfgRamInit, .cfgWe, .cfgAddr, .cfgWdata, .cfgRdata, .keyReq, .keySel, .firstLookup,
    .indexIsService, .genericIndex, .ingressPort, .outerTagProtocolCode, .outerPcp, .outerDei, .outerVid,
    .secondTagProtocolCode, .secondPcp, .secondDei, .secondVid, .thirdTagProtocolCode, .thirdPcp, .thirdDei,
    .thirdVid, .etypeClass, .lbl0, .tc0, .sbit0, .ttl0Expiry, .lbl1, .tc1, .sbit1, .ttl1Expiry, .rsvLblPos,
    .keyValid, .keyData, .keyWidth, .keyClass, .keyWords);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed[31:0];
  endfunction
  task automatic check(input logic [553:0] got, input logic [553:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reference key, packed from bit 0 upward; pushed with the inputs the design takes at this edge
  always @(posedge clk_sys) begin
    if (rst_n && keyReq) begin
      case (keySel)
        ckl_pkg::CKL_SGL_LBL: ek = 536'({ttl0Expiry, sbit0, lbl0, genericIndex, firstLookup});
        ckl_pkg::CKL_THREE_VLAN: ek = 536'({etypeClass, thirdVid, thirdDei, thirdPcp, thirdTagProtocolCode, secondVid,
          secondDei, secondPcp, secondTagProtocolCode, outerVid, outerDei, outerPcp, outerTagProtocolCode,
          ingressPort, firstLookup, 2'h0});
        ckl_pkg::CKL_DBL_LBL: ek = 536'({rsvLblPos, ttl1Expiry, sbit1, tc1, lbl1, ttl0Expiry, sbit0, tc0, lbl0,
          genericIndex, firstLookup, 2'h1});
        default: ek = 536'({thirdVid, thirdTagProtocolCode, secondVid, secondTagProtocolCode, outerVid,
          outerTagProtocolCode, genericIndex, indexIsService, firstLookup, 2'h2});
      endcase
      q.push_back({ek, keySel == ckl_pkg::CKL_SGL_LBL ? {10'h023, 5'h01, ckl_pkg::CKL_X1} :
        {keySel == ckl_pkg::CKL_DBL_LBL ? 10'h044 : 10'h045, 5'h02, ckl_pkg::CKL_X2}});
    end
  end
  // compare mid-cycle so the registered outputs have settled
  always @(negedge clk_sys) begin
    if (keyValid === 1'b1) begin
      if (q.size() == 0) check(1'b0, 1'b1);
      else check({keyData, keyWidth, keyWords, keyClass}, q.pop_front());
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    cfgRamEnable <= 1'b1;
    cfgRamInitSet <= 1'b1;
    @(posedge clk_sys);
    cfgRamInitSet <= 1'b0;
    i = 0;
    @(negedge clk_sys);
    while (cfgRamInit === 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i++;
    end
    check(i, 256);
    // back-to-back writes, then one write with the enable low that must be dropped
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      mem[i] = rnd();
      cfgWe <= 1'b1;
      cfgAddr <= 8'(i * 37);
      cfgWdata <= mem[i];
    end
    @(posedge clk_sys);
    cfgRamEnable <= 1'b0;
    cfgAddr <= 8'h00;
    cfgWdata <= ~mem[0];
    @(posedge clk_sys);
    cfgWe <= 1'b0;
    cfgRamEnable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      cfgAddr <= 8'(i * 37);
      @(posedge clk_sys);
      #1 check(cfgRdata, mem[i]);
    end
    // a word never written must read as cleared by the sweep
    @(posedge clk_sys);
    cfgAddr <= 8'h01;
    @(posedge clk_sys);
    #1 check(cfgRdata, 32'h0);
    // every key type in turn: first half back to back, then random gaps
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      keyReq <= (i < 20) | 1'(rnd());
      keySel <= ckl_pkg::ckl_key_t'(i % 4);
      {firstLookup, indexIsService, genericIndex, ingressPort, outerTagProtocolCode, outerPcp, outerDei, outerVid,
        secondTagProtocolCode, secondPcp, secondDei, secondVid, thirdTagProtocolCode, thirdPcp, thirdDei, thirdVid,
        etypeClass, lbl0, tc0, sbit0, ttl0Expiry, lbl1, tc1, sbit1, ttl1Expiry, rsvLblPos}
        <= 133'({rnd(), rnd(), rnd(), rnd(), rnd()});
    end
    @(posedge clk_sys);
    keyReq <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(q.size(), 0);
    give_verdict();
  end
endmodule
bind ckl_classifier_key_layout_init ckl_key_checker ckl_key_checker_inst (.clk_sys, .rst_n, .cfgRamEnable,
  .cfgRamInitSet, .cfgRamInit, .keyReq, .keySel, .firstLookup, .keyValid, .keyData, .keyWidth, .keyWords);
